// >>> core/osc_pkg.sv
// package for the output shutdown control block: register map, fields, timing
// assumes a 32-bit classic wishbone slave with word-aligned registers
package osc_pkg;
   // register byte offsets
   localparam logic [3:0] OSC_ADDR_INPUT = 4'h0; // input_level_ctrl_status
   localparam logic [3:0] OSC_ADDR_OUTPUT = 4'h4; // output_compare_ctrl_status
   localparam logic [3:0] OSC_ADDR_PINS = 4'h8; // live pin and shutdown status
   // input register fields
   localparam int OSC_IN_FLAG_LSB = 12;
   localparam int OSC_IN_IRQ_EN_BIT = 8;
   localparam int OSC_MODE_W = 2;
   // output register fields
   localparam int OSC_OUT_SHORT_BIT = 15;
   localparam int OSC_OUT_CMP_EN_BIT = 9;
   localparam int OSC_OUT_IRQ_EN_BIT = 8;
   // reset values
   localparam logic [15:0] OSC_RESET_VAL = 16'h0000;
   // filter modes
   localparam logic [1:0] OSC_MODE_EDGE = 2'h0;
   localparam logic [1:0] OSC_MODE_DIV8 = 2'h1;
   localparam logic [1:0] OSC_MODE_DIV16 = 2'h2;
   localparam logic [1:0] OSC_MODE_DIV128 = 2'h3;
   // sampling
   localparam int OSC_SAMPLES = 16;
   localparam logic [4:0] OSC_SAMPLES_5 = 5'h10;
   localparam int OSC_PRESCALE_W = 7;
   // short must persist longer than one clock cycle before it counts
   // one low cycle is a normal dead-time glitch, two in a row is a short
   localparam int OSC_SHORT_CYC = 2;
   localparam logic [1:0] OSC_SHORT_CYC_2 = 2'(OSC_SHORT_CYC);
endpackage : osc_pkg

// >>> core/osc_top.sv
// output shutdown control: request filters, complementary-pair compare,
// flags, and the high-impedance request for the high-current pins
// assumes request pins are asynchronous, timer outputs are on core_clk,
// and rst_n is the power-on reset only
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: request 2 mode selects edge or filters
// R2: request 1 mode uses same encoding
// R3: request 0 mode uses same encoding
// R4: edge mode accepts high-to-low change
// R5: sixteen consecutive low samples, high restarts
// R6: any request floats all high-current pins
// R7: compare register reset only by power-on
// R8: short flag sets on simultaneous pair lows
// R9: short flag cleared by zero after one
// R10: compare without irq enable gives no request
// R11: both enables give float and irq together
// R12: already shorted pair sets flag immediately; here it sets only after the two-cycle short filter
// R13: reserved compare bits read zero
// R14: input float released by clearing all flags
// R15: software disables compare before clearing flag
// R16: software drives timer outputs high first
// R17: software enables compare after pin setup
// R18: request inputs held high before level use
// R19: input flags set, hold float, read-then-clear
// R20: input irq enable gates input interrupt
// R21: pair short must outlast one cycle
// R22: synchronise inputs, free-running prescaler
module osc_top (
   // clock and power-on reset
   input wire logic core_clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // shutdown request pins, active low
   input wire logic [3:0] shutdown_request_in_n,
   // compared timer outputs
   input wire logic timer3_out_b,
   input wire logic timer3_out_d,
   input wire logic timer4_out_a,
   input wire logic timer4_out_b,
   input wire logic timer4_out_c,
   input wire logic timer4_out_d,
   // results
   output logic hiz_req,
   output logic input_irq,
   output logic short_irq,
   output logic [5:0] port_e_force_high
);
   import osc_pkg::*;

   logic [15:0] in_reg_r;
   logic [15:0] out_reg_r;
   logic [3:0] in_seen_r;
   logic out_seen_r;
   logic [3:0] sync_a_r, sync_b_r, prev_r;
   logic [OSC_PRESCALE_W-1:0] presc_r;
   logic [4:0] cnt_r [4];
   logic [3:0] accept;
   logic [2:0] pair_low;
   logic [1:0] pair_cnt_r [3];
   logic short_det;
   logic wr, rd, wr_in, wr_out;
   logic [2:0] tick;

   // bus strobes; only the low half-word carries register data
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign wr_in = wr && (wb_adr_i == OSC_ADDR_INPUT);
   assign wr_out = wr && (wb_adr_i == OSC_ADDR_OUTPUT);

   // two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a_r <= 4'hF;
         sync_b_r <= 4'hF;
         prev_r <= 4'hF;
      end else begin
         sync_a_r <= shutdown_request_in_n; // R22
         sync_b_r <= sync_a_r;
         prev_r <= sync_b_r;
      end
   end

   // free-running prescaler for the divided sampling enables
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) presc_r <= '0;
      else presc_r <= presc_r + 7'h01; // R22
   end
   assign tick[0] = (presc_r[2:0] == 3'h7);
   assign tick[1] = (presc_r[3:0] == 4'hF);
   assign tick[2] = (presc_r == 7'h7F);

   // per-input filter: edge or sixteen consecutive lows
   for (genvar i = 0; i < 4; i++) begin : g_filt
      logic [1:0] mode;
      logic en;
      assign mode = in_reg_r[2*i +: OSC_MODE_W]; // R1 R2 R3
      assign en = (mode == OSC_MODE_DIV8) ? tick[0] :
                  (mode == OSC_MODE_DIV16) ? tick[1] :
                  (mode == OSC_MODE_DIV128) ? tick[2] : 1'b0;
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            cnt_r[i] <= '0;
         end else if (mode == OSC_MODE_EDGE) begin
            cnt_r[i] <= '0;
         end else if (en) begin
            // a high sample throws the partial run away
            if (sync_b_r[i]) cnt_r[i] <= '0; // R5
            else if (cnt_r[i] != OSC_SAMPLES_5) cnt_r[i] <= cnt_r[i] + 5'h01;
         end
      end
      assign accept[i] = (mode == OSC_MODE_EDGE) ? (prev_r[i] && !sync_b_r[i]) : // R4
                         (en && !sync_b_r[i] && cnt_r[i] == OSC_SAMPLES_5 - 5'h01); // R5
   end

   // complementary pairs: low on both for longer than one cycle
   assign pair_low[0] = !timer3_out_b && !timer3_out_d;
   assign pair_low[1] = !timer4_out_a && !timer4_out_c;
   assign pair_low[2] = !timer4_out_b && !timer4_out_d;
   for (genvar p = 0; p < 3; p++) begin : g_pair
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) pair_cnt_r[p] <= '0;
         else if (!pair_low[p] || !out_reg_r[OSC_OUT_CMP_EN_BIT]) pair_cnt_r[p] <= '0;
         else if (pair_cnt_r[p] != 2'h3) pair_cnt_r[p] <= pair_cnt_r[p] + 2'h1; // R21
      end
   end
   // a pair already low when compare turns on trips after the same filter
   assign short_det = (pair_cnt_r[0] >= OSC_SHORT_CYC_2) ||
                      (pair_cnt_r[1] >= OSC_SHORT_CYC_2) ||
                      (pair_cnt_r[2] >= OSC_SHORT_CYC_2); // R8 R12

   // input register: flags set wins over clear, modes and irq enable writable
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_reg_r <= OSC_RESET_VAL;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (accept[k]) in_reg_r[OSC_IN_FLAG_LSB+k] <= 1'b1; // R19
            else if (wr_in && wb_sel_i[1] && in_seen_r[k] &&
                     !wb_dat_i[OSC_IN_FLAG_LSB+k])
               in_reg_r[OSC_IN_FLAG_LSB+k] <= 1'b0; // R19
         end
         if (wr_in && wb_sel_i[1]) in_reg_r[OSC_IN_IRQ_EN_BIT] <= wb_dat_i[OSC_IN_IRQ_EN_BIT];
         if (wr_in && wb_sel_i[0]) in_reg_r[7:0] <= wb_dat_i[7:0];
      end
   end

   // output register: power-on reset only, reserved bits never stored
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_reg_r <= OSC_RESET_VAL; // R7
      end else begin
         if (short_det) out_reg_r[OSC_OUT_SHORT_BIT] <= 1'b1; // R8
         else if (wr_out && wb_sel_i[1] && out_seen_r && !wb_dat_i[OSC_OUT_SHORT_BIT])
            out_reg_r[OSC_OUT_SHORT_BIT] <= 1'b0; // R9
         if (wr_out && wb_sel_i[1]) begin
            out_reg_r[OSC_OUT_CMP_EN_BIT] <= wb_dat_i[OSC_OUT_CMP_EN_BIT];
            out_reg_r[OSC_OUT_IRQ_EN_BIT] <= wb_dat_i[OSC_OUT_IRQ_EN_BIT];
         end
      end
   end

   // read-as-one memory for the read-then-clear protocol
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_seen_r <= '0;
         out_seen_r <= 1'b0;
      end else begin
         if (rd && wb_adr_i == OSC_ADDR_INPUT)
            in_seen_r <= in_reg_r[OSC_IN_FLAG_LSB +: 4]; // R19
         else if (wr_in && wb_sel_i[1])
            in_seen_r <= '0;
         if (rd && wb_adr_i == OSC_ADDR_OUTPUT)
            out_seen_r <= out_reg_r[OSC_OUT_SHORT_BIT]; // R9
         else if (wr_out && wb_sel_i[1])
            out_seen_r <= 1'b0;
      end
   end

   // bus answer: ack one cycle after the strobe, unmapped reads zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (rd) begin
            case (wb_adr_i)
               OSC_ADDR_INPUT: wb_dat_o <= {16'h0000, in_reg_r & 16'hF1FF};
               OSC_ADDR_OUTPUT: wb_dat_o <= {16'h0000, out_reg_r & 16'h8300}; // R13
               OSC_ADDR_PINS: wb_dat_o <= {24'h000000, hiz_req, pair_low, sync_b_r};
               default: wb_dat_o <= '0;
            endcase
         end
      end
   end

   // high-impedance request and interrupts, all registered
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hiz_req <= 1'b0;
         input_irq <= 1'b0;
         short_irq <= 1'b0;
         port_e_force_high <= '0;
      end else begin
         // input float holds until all four flags are clear
         hiz_req <= (|in_reg_r[OSC_IN_FLAG_LSB +: 4]) || // R6 R14 R19
                    (out_reg_r[OSC_OUT_SHORT_BIT] && out_reg_r[OSC_OUT_CMP_EN_BIT] &&
                     out_reg_r[OSC_OUT_IRQ_EN_BIT]); // R10 R11
         input_irq <= in_reg_r[OSC_IN_IRQ_EN_BIT] && (|in_reg_r[OSC_IN_FLAG_LSB +: 4]); // R20
         short_irq <= out_reg_r[OSC_OUT_SHORT_BIT] && out_reg_r[OSC_OUT_CMP_EN_BIT] &&
                      out_reg_r[OSC_OUT_IRQ_EN_BIT]; // R11
         // port data bits 15..11 and 9 forced to one on a compare trip
         if (short_det) port_e_force_high <= 6'h3F; // R12
         else if (!out_reg_r[OSC_OUT_SHORT_BIT]) port_e_force_high <= '0;
      end
   end

   // checks
   property p_short_sets;
      @(posedge core_clk) disable iff (!rst_n) short_det |=> out_reg_r[OSC_OUT_SHORT_BIT];
   endproperty
   a_short_sets: assert property (p_short_sets) else $error("short flag not set"); // R8
   property p_no_req_without_oie;
      @(posedge core_clk) disable iff (!rst_n)
         !out_reg_r[OSC_OUT_IRQ_EN_BIT] && in_reg_r[15:12] == 4'h0 |=> !hiz_req;
   endproperty
   a_no_req_without_oie: assert property (p_no_req_without_oie) else $error("float without oie"); // R10
   property p_req_irq_together;
      @(posedge core_clk) disable iff (!rst_n) short_irq |-> hiz_req;
   endproperty
   a_req_irq_together: assert property (p_req_irq_together) else $error("irq without float"); // R11
   property p_input_float;
      @(posedge core_clk) disable iff (!rst_n) |accept |=> ##1 hiz_req;
   endproperty
   a_input_float: assert property (p_input_float) else $error("request did not float"); // R6
   property p_short_filter;
      @(posedge core_clk) disable iff (!rst_n) short_det |-> $past(pair_low != 3'h0);
   endproperty
   a_short_filter: assert property (p_short_filter) else $error("single-cycle short"); // R21
   property p_edge_accept;
      @(posedge core_clk) disable iff (!rst_n)
         in_reg_r[1:0] == OSC_MODE_EDGE && prev_r[0] && !sync_b_r[0] |=> in_reg_r[12];
   endproperty
   a_edge_accept: assert property (p_edge_accept) else $error("edge missed"); // R4
   property p_level_needs_low;
      @(posedge core_clk) disable iff (!rst_n)
         in_reg_r[1:0] != OSC_MODE_EDGE && accept[0] |-> cnt_r[0] == 5'h0F;
   endproperty
   a_level_needs_low: assert property (p_level_needs_low) else $error("short run accepted"); // R5
   property p_reserved_zero;
      @(posedge core_clk) disable iff (!rst_n) out_reg_r[7:0] == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // R13
   property p_irq_gate;
      @(posedge core_clk) disable iff (!rst_n) !in_reg_r[8] && !$past(in_reg_r[8]) |-> !input_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("ungated input irq"); // R20

   // a set input flag keeps the pins floating
   property p_flag_holds_float;
      @(posedge core_clk) disable iff (!rst_n) |in_reg_r[15:12] |=> hiz_req;
   endproperty
   a_flag_holds_float: assert property (p_flag_holds_float) else $error("flag without float"); // R19

   // float drops once every cause is gone
   property p_input_release;
      @(posedge core_clk) disable iff (!rst_n)
         in_reg_r[15:12] == 4'h0 && !(out_reg_r[15] && out_reg_r[9] && out_reg_r[8]) |=> !hiz_req;
   endproperty
   a_input_release: assert property (p_input_release) else $error("float not released"); // R14

   // the trip needs the same pair low on two sampled edges
   property p_short_two_cycles;
      @(posedge core_clk) disable iff (!rst_n)
         short_det |-> $past(pair_low) != 3'h0 && $past(pair_low, 2) != 3'h0;
   endproperty
   a_short_two_cycles: assert property (p_short_two_cycles) else $error("short too brief"); // R21

   // short flag survives a write unless it was read as one
   property p_short_keeps;
      @(posedge core_clk) disable iff (!rst_n)
         out_reg_r[15] && !out_seen_r |=> out_reg_r[15];
   endproperty
   a_short_keeps: assert property (p_short_keeps) else $error("short flag lost"); // R9

   // input flag 0 survives a write unless it was read as one
   property p_in_flag_keeps;
      @(posedge core_clk) disable iff (!rst_n)
         in_reg_r[12] && !in_seen_r[0] |=> in_reg_r[12];
   endproperty
   a_in_flag_keeps: assert property (p_in_flag_keeps) else $error("input flag lost"); // R19

   // compare trip forces the port data bits high
   property p_port_force;
      @(posedge core_clk) disable iff (!rst_n) short_det |=> port_e_force_high == 6'h3F;
   endproperty
   a_port_force: assert property (p_port_force) else $error("port bits not forced"); // R12

   // enabled input flag always raises the interrupt
   property p_input_irq_on;
      @(posedge core_clk) disable iff (!rst_n) in_reg_r[8] && |in_reg_r[15:12] |=> input_irq;
   endproperty
   a_input_irq_on: assert property (p_input_irq_on) else $error("input irq missing"); // R20

   // compare disabled means no comparison runs
   property p_cmp_idle;
      @(posedge core_clk) disable iff (!rst_n) !out_reg_r[9] |=> !short_det;
   endproperty
   a_cmp_idle: assert property (p_cmp_idle) else $error("compare ran while off"); // R10

   // short interrupt only with both enables set
   property p_short_irq_gate;
      @(posedge core_clk) disable iff (!rst_n)
         short_irq |-> $past(out_reg_r[9] && out_reg_r[8] && out_reg_r[15]);
   endproperty
   a_short_irq_gate: assert property (p_short_irq_gate) else $error("ungated short irq"); // R11

   // a high sample on the divider tick restarts the low run
   property p_level_restart;
      @(posedge core_clk) disable iff (!rst_n)
         in_reg_r[1:0] == OSC_MODE_DIV8 && tick[0] && sync_b_r[0] |=> cnt_r[0] == 5'h00;
   endproperty
   a_level_restart: assert property (p_level_restart) else $error("high did not restart"); // R5

   // prescaler never stops or skips, so tick spacing is exact
   property p_presc_runs;
      @(posedge core_clk) disable iff (!rst_n)
         $past(rst_n) |-> presc_r == 7'($past(presc_r) + 7'h01);
   endproperty
   a_presc_runs: assert property (p_presc_runs) else $error("prescaler stalled"); // R22

   // reserved compare bits read back as zero on the bus
   property p_out_rsvd_read;
      @(posedge core_clk) disable iff (!rst_n)
         $past(rd && wb_adr_i == OSC_ADDR_OUTPUT) |-> wb_dat_o[14:10] == 5'h00 &&
            wb_dat_o[7:0] == 8'h00;
   endproperty
   a_out_rsvd_read: assert property (p_out_rsvd_read) else $error("reserved bits read"); // R13

   // bus answer is a single-cycle pulse
   property p_ack_pulse;
      @(posedge core_clk) disable iff (!rst_n) wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
endmodule : osc_top
`default_nettype wire

// >>> verification/osc_fault_src.sv
// model of the external fault circuit that pulls one shutdown request pin low
// assumes the pins have pull-ups, so a released pin reads high
`timescale 1ns/1ps
`default_nettype none
module osc_fault_src (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // command from the bench
   input wire logic go,
   input wire logic [1:0] pin_sel,
   input wire logic [15:0] low_len,
   // state and pins
   output logic busy,
   output logic [3:0] req_n
);
   logic [15:0] cnt_r;
   // hold one pin low for low_len cycles, then release it to the pull-up
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 16'h0000;
         req_n <= 4'hF;
      end else if (go) begin
         cnt_r <= low_len;
         req_n <= ~(4'h1 << pin_sel);
      end else if (cnt_r > 16'h0001) begin
         cnt_r <= cnt_r - 16'h0001;
      end else begin
         cnt_r <= 16'h0000;
         req_n <= 4'hF;
      end
   end
   assign busy = (cnt_r != 16'h0000);
endmodule : osc_fault_src
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the output shutdown block over classic wishbone
// assumes a one-cycle ack; reads are checked by a monitor against a queue
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import osc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic go = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [5:0] tmr = 6'h3F;
   logic [1:0] psel = 2'h0;
   logic [15:0] plen = 16'h0000;
   logic [31:0] seed = 32'h00000033;
   logic [5:0] pm;
   logic [15:0] md;
   logic [25:0] expq[$];
   logic [25:0] e;
   wire logic busy, ack, hiz, iirq, sirq;
   wire logic [3:0] req_n;
   wire logic [5:0] pe;
   wire logic [31:0] rdat;
   int bad_count = 0;
   int checks_done = 0;
   int div;
   always #50 core_clk = ~core_clk;
   osc_fault_src u_osc_fault_src (.core_clk(core_clk), .rst_n(rst_n), .go(go),
      .pin_sel(psel), .low_len(plen), .busy(busy), .req_n(req_n));
   osc_top u_osc_top (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .shutdown_request_in_n(req_n), .timer3_out_b(tmr[0]),
      .timer3_out_d(tmr[1]), .timer4_out_a(tmr[2]), .timer4_out_b(tmr[3]),
      .timer4_out_c(tmr[4]), .timer4_out_d(tmr[5]), .hiz_req(hiz), .input_irq(iirq),
      .short_irq(sirq), .port_e_force_high(pe));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic conclude();
      if (bad_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= {16'h0000, d};
      do @(posedge core_clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   // note data and, if care, {hiz, input irq, short irq, port forcing}
   task automatic rd(input logic [3:0] a, input logic [15:0] d, input logic [8:0] st,
      input logic c);
      expq.push_back({c, st, d});
      bus(a, 1'b0, 16'h0000);
   endtask : rd
   task automatic pulse(input logic [1:0] i, input int n);
      psel <= i;
      plen <= 16'(n);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      @(posedge core_clk);
      while (busy === 1'b1) @(posedge core_clk);
   endtask : pulse
   // read results are taken at the ack edge, oldest note first
   always @(posedge core_clk) begin
      if (ack === 1'b1 && cyc && !we && expq.size() > 0) begin
         e = expq.pop_front();
         checks_done++;
         if (rdat !== {16'h0000, e[15:0]} || (e[25] && {hiz, iirq, sirq, pe} !== e[24:16])) begin
            bad_count++;
            $display("unexpected read %h: expected %h seen %h", adr, e[24:0],
               {hiz, iirq, sirq, pe, rdat[15:0]});
         end
      end
   end
   // hang guard, a few times the expected run length
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(OSC_ADDR_INPUT, 16'h0000, 9'h000, 1'b1);
      rd(OSC_ADDR_OUTPUT, 16'h0000, 9'h000, 1'b1);
      bus(OSC_ADDR_OUTPUT, 1'b1, 16'hFFFF);
      rd(OSC_ADDR_OUTPUT, 16'h0300, 9'h000, 1'b1);
      bus(OSC_ADDR_INPUT, 1'b1, 16'h0100);
      seed = xs(seed);
      pulse(seed[1:0], 5);
      rd(OSC_ADDR_INPUT, 16'h0100 | (16'h1000 << seed[1:0]), 9'h180, 1'b1);
      bus(OSC_ADDR_INPUT, 1'b1, 16'h0100);
      rd(OSC_ADDR_INPUT, 16'h0100, 9'h000, 1'b1);
      // input m-1 uses mode m: a short low run is refused, a long one taken
      for (int m = 1; m <= 3; m++) begin
         div = (m == 3) ? 128 : 8 * m;
         md = 16'h0100 | 16'(m << (2 * (m - 1)));
         bus(OSC_ADDR_INPUT, 1'b1, md);
         pulse(2'(m - 1), 12 * div);
         rd(OSC_ADDR_INPUT, md, 9'h000, 1'b1);
         pulse(2'(m - 1), 18 * div);
         rd(OSC_ADDR_INPUT, md | (16'h1000 << (m - 1)), 9'h180, 1'b1);
         bus(OSC_ADDR_INPUT, 1'b1, md);
      end
      seed = xs(seed);
      pm = (seed[1:0] == 2'h0) ? 6'h03 : (seed[1:0] == 2'h1) ? 6'h14 : 6'h28;
      bus(OSC_ADDR_OUTPUT, 1'b1, 16'h0200);
      tmr <= ~pm;
      repeat (4) @(posedge core_clk);
      rd(OSC_ADDR_OUTPUT, 16'h8200, 9'h03F, 1'b1);
      bus(OSC_ADDR_OUTPUT, 1'b1, 16'h0300);
      rd(OSC_ADDR_OUTPUT, 16'h8300, 9'h17F, 1'b1);
      tmr <= 6'h3F;
      bus(OSC_ADDR_OUTPUT, 1'b1, 16'h0100);
      rd(OSC_ADDR_OUTPUT, 16'h8100, 9'h03F, 1'b1);
      bus(OSC_ADDR_OUTPUT, 1'b1, 16'h0000);
      rd(OSC_ADDR_OUTPUT, 16'h0000, 9'h000, 1'b1);
      bus(OSC_ADDR_OUTPUT, 1'b1, 16'h0300);
      tmr <= ~pm;
      @(posedge core_clk);
      tmr <= 6'h3F;
      rd(OSC_ADDR_OUTPUT, 16'h0300, 9'h000, 1'b1);
      bus(OSC_ADDR_OUTPUT, 1'b1, 16'h0000);
      tmr <= ~pm;
      repeat (3) @(posedge core_clk);
      bus(OSC_ADDR_OUTPUT, 1'b1, 16'h0300);
      repeat (4) @(posedge core_clk);
      rd(OSC_ADDR_OUTPUT, 16'h8300, 9'h17F, 1'b1);
      conclude();
   end
endmodule : testbench
`default_nettype wire
